// ===== verilog/lbw_pkg.sv
package lbw_pkg;
    // register indices on the plain port
    localparam logic [2:0]  ADDR_CTRL   = 3'h0;
    localparam logic [2:0]  ADDR_STAT   = 3'h1;
    localparam logic [2:0]  ADDR_TXD    = 3'h2;
    localparam logic [2:0]  ADDR_RXD    = 3'h3;
    localparam logic [2:0]  ADDR_BAUD   = 3'h4;
    // status bit positions
    localparam int          ST_RXRDY    = 0;
    localparam int          ST_FRAMING_ERROR_FLAG     = 1;
    localparam int          ST_TXRDY    = 2;
    localparam int          ST_TX_SHIFT_EMPTY     = 3;
    localparam int          ST_RXIDLE   = 4;
    // reset values
    localparam logic [4:0]  CTRL_RST    = 5'h10;
    localparam logic [15:0] BAUD_RST    = 16'h0364;
    // data bits per frame, and the byte a break sends
    localparam logic [3:0]  BRK_BITS    = 4'hc;
    localparam logic [3:0]  DATA_BITS   = 4'h8;
    localparam logic [7:0]  BRK_DATA    = 8'h00;

    typedef struct packed {
        logic async_mode;
        logic autobaud_arm;
        logic wake_arm;
        logic send_break_bit;
        logic tx_enable_bit;
    } lbw_ctrl_t;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} lbw_tx_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} lbw_rx_t;
endpackage : lbw_pkg

// ===== verilog/lbw_top.sv
// Functional notes
// R1: remote wake character all zeros, ten bits
// R2: non-zero character's first low is wake
// R3: wake event sets receive-ready flag
// R4: rising receive edge clears wake arm
// R5: reading receive data drops ready flag
// R6: software checks receiver idle before arming
// R7: receiver held idle while wake armed
// R8: break is start, twelve zeros, stop
// R9: break write ignores data, sends zeros
// R10: send-break clears after stop; buffered byte follows
// R11: shift-empty status tracks break like characters
// R12: header is break then sync 55h
// R13: transmit-ready rises when holding register empties
// R14: received break: ready, framing error, 00h
// R15: armed wake takes two edges, then byte
// R16: remote break long enough for wakeup
// R17: software may arm autobaud before sleep
// R18: falling receive edge is wake event
// R19: wake detection only in asynchronous mode
// R20: wake plus autobaud measures following byte
// R21: break bits use normal baud period
`timescale 1ns/1ps
module lbw_top (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [2:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    input  wire logic        rx_data_line,
    output logic             tx_line,
    output logic             rx_ready_flag,
    output logic             tx_ready_flag
);
    lbw_pkg::lbw_ctrl_t ctrl_r, ctrl_nxt;
    logic [15:0]        baud_r, baud_nxt, rdata_nxt;
    logic               rxrdy_nxt, framing_error_flag_r, framing_error_flag_nxt;
    logic [7:0]         rxd_r, rxd_nxt, rsh_r, rsh_nxt;
    logic               rx_prev_r, wake_seen_r, wake_seen_nxt;
    logic               ab_run_r, ab_run_nxt;
    logic [15:0]        ab_cnt_r, ab_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
    logic [3:0]         rx_bits_r, rx_bits_nxt;
    lbw_pkg::lbw_rx_t   rx_st_r, rx_st_nxt;
    logic               fall, rise, rx_set, wake_ev, send_break_bit_clr;
    logic [7:0]         txh_r, txh_nxt, tsr_r, tsr_nxt;
    logic               txh_full_r, txh_full_nxt, brk_r, brk_nxt;
    logic               tx_line_nxt;
    logic [15:0]        tx_cnt_r, tx_cnt_nxt;
    logic [3:0]         tx_bits_r, tx_bits_nxt, tx_last;
    lbw_pkg::lbw_tx_t   tx_st_r, tx_st_nxt;

    assign fall = rx_prev_r & ~rx_data_line;
    assign rise = ~rx_prev_r & rx_data_line;

    // bus, wake, autobaud and receiver: next values
    always_comb begin
        ctrl_nxt      = ctrl_r;
        baud_nxt      = baud_r;
        rxrdy_nxt     = rx_ready_flag;
        framing_error_flag_nxt      = framing_error_flag_r;
        rxd_nxt       = rxd_r;
        rsh_nxt       = rsh_r;
        wake_seen_nxt = wake_seen_r;
        ab_run_nxt    = ab_run_r;
        ab_cnt_nxt    = ab_cnt_r;
        rx_cnt_nxt    = rx_cnt_r;
        rx_bits_nxt   = rx_bits_r;
        rx_st_nxt     = rx_st_r;
        rx_set        = 1'b0;
        wake_ev       = 1'b0;
        rdata_nxt     = 16'h0000;
        // software writes first; hardware clears below may override
        if (wr && addr == lbw_pkg::ADDR_CTRL) begin
            ctrl_nxt = lbw_pkg::lbw_ctrl_t'(wdata[4:0]);
        end else if (wr && addr == lbw_pkg::ADDR_BAUD) begin
            baud_nxt = wdata;
        end
        // R10 send-break self clear
        if (send_break_bit_clr) begin
            ctrl_nxt.send_break_bit = 1'b0;
        end
        // R19 R15 wake watch in async mode only
        if (ctrl_r.wake_arm && ctrl_r.async_mode) begin
            // R18 falling edge wakes
            if (fall && !wake_seen_r) begin
                wake_seen_nxt = 1'b1;
                wake_ev       = 1'b1;
            end
            // R4 R2 first rising edge disarms
            if (rise && wake_seen_r) begin
                ctrl_nxt.wake_arm = 1'b0;
                wake_seen_nxt     = 1'b0;
            end
        end else begin
            wake_seen_nxt = 1'b0;
        end
        // R20 measure one low bit of the byte after the break
        if (ctrl_r.autobaud_arm && !ctrl_r.wake_arm) begin
            if (!ab_run_r && fall) begin
                ab_run_nxt = 1'b1;
                ab_cnt_nxt = 16'h0001;
            end else if (ab_run_r && rise) begin
                ab_run_nxt            = 1'b0;
                baud_nxt              = ab_cnt_r;
                ctrl_nxt.autobaud_arm = 1'b0;
                rx_set                = 1'b1;
            end else if (ab_run_r) begin
                ab_cnt_nxt = ab_cnt_r + 16'h0001;
            end
        end else begin
            ab_run_nxt = 1'b0;
        end
        // R7 receiver parked while wake or autobaud armed
        if (ctrl_r.wake_arm || ctrl_r.autobaud_arm) begin
            rx_st_nxt = lbw_pkg::RX_IDLE;
        end else begin
            case (rx_st_r)
                lbw_pkg::RX_IDLE: begin
                    if (fall) begin
                        rx_st_nxt  = lbw_pkg::RX_START;
                        rx_cnt_nxt = {1'b0, baud_r[15:1]};
                    end
                end
                lbw_pkg::RX_START: begin
                    if (rx_cnt_r == 16'h0000) begin
                        // glitch shorter than half a bit is dropped
                        rx_st_nxt   = rx_data_line ? lbw_pkg::RX_IDLE
                                                   : lbw_pkg::RX_DATA;
                        rx_cnt_nxt  = baud_r - 16'h0001;
                        rx_bits_nxt = 4'h0;
                    end else begin
                        rx_cnt_nxt = rx_cnt_r - 16'h0001;
                    end
                end
                lbw_pkg::RX_DATA: begin
                    if (rx_cnt_r == 16'h0000) begin
                        rsh_nxt     = {rx_data_line, rsh_r[7:1]};
                        rx_cnt_nxt  = baud_r - 16'h0001;
                        rx_bits_nxt = rx_bits_r + 4'h1;
                        if (rx_bits_r == lbw_pkg::DATA_BITS - 4'h1) begin
                            rx_st_nxt = lbw_pkg::RX_STOP;
                        end
                    end else begin
                        rx_cnt_nxt = rx_cnt_r - 16'h0001;
                    end
                end
                lbw_pkg::RX_STOP: begin
                    if (rx_cnt_r == 16'h0000) begin
                        // R14 low stop bit flags framing error
                        rxd_nxt   = rsh_r;
                        framing_error_flag_nxt  = ~rx_data_line;
                        rx_set    = 1'b1;
                        rx_st_nxt = lbw_pkg::RX_IDLE;
                    end else begin
                        rx_cnt_nxt = rx_cnt_r - 16'h0001;
                    end
                end
                default: rx_st_nxt = lbw_pkg::RX_IDLE;
            endcase
        end
        // R5 reading data drops ready; R3 a new event wins
        if (rd && addr == lbw_pkg::ADDR_RXD) begin
            rxrdy_nxt = 1'b0;
        end
        if (rx_set || wake_ev) begin
            rxrdy_nxt = 1'b1;
        end
        // read data, registered for the cycle after the strobe
        if (rd && addr == lbw_pkg::ADDR_CTRL) begin
            rdata_nxt = {11'h000, ctrl_r};
        end else if (rd && addr == lbw_pkg::ADDR_STAT) begin
            rdata_nxt[lbw_pkg::ST_RXRDY]  = rx_ready_flag;
            rdata_nxt[lbw_pkg::ST_FRAMING_ERROR_FLAG]   = framing_error_flag_r;
            rdata_nxt[lbw_pkg::ST_TXRDY]  = tx_ready_flag;
            // R11 same busy indication for break frames
            rdata_nxt[lbw_pkg::ST_TX_SHIFT_EMPTY]   = (tx_st_r == lbw_pkg::TX_IDLE);
            rdata_nxt[lbw_pkg::ST_RXIDLE] = (rx_st_r == lbw_pkg::RX_IDLE);
        end else if (rd && addr == lbw_pkg::ADDR_RXD) begin
            rdata_nxt = {8'h00, rxd_r};
        end else if (rd && addr == lbw_pkg::ADDR_BAUD) begin
            rdata_nxt = baud_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r        <= lbw_pkg::CTRL_RST;
            baud_r        <= lbw_pkg::BAUD_RST;
            rx_ready_flag <= 1'b0;
            framing_error_flag_r        <= 1'b0;
            rxd_r         <= 8'h00;
            rsh_r         <= 8'h00;
            rx_prev_r     <= 1'b1;
            wake_seen_r   <= 1'b0;
            ab_run_r      <= 1'b0;
            ab_cnt_r      <= 16'h0000;
            rx_cnt_r      <= 16'h0000;
            rx_bits_r     <= 4'h0;
            rx_st_r       <= lbw_pkg::RX_IDLE;
            rdata         <= 16'h0000;
        end else begin
            ctrl_r        <= ctrl_nxt;
            baud_r        <= baud_nxt;
            rx_ready_flag <= rxrdy_nxt;
            framing_error_flag_r        <= framing_error_flag_nxt;
            rxd_r         <= rxd_nxt;
            rsh_r         <= rsh_nxt;
            rx_prev_r     <= rx_data_line;
            wake_seen_r   <= wake_seen_nxt;
            ab_run_r      <= ab_run_nxt;
            ab_cnt_r      <= ab_cnt_nxt;
            rx_cnt_r      <= rx_cnt_nxt;
            rx_bits_r     <= rx_bits_nxt;
            rx_st_r       <= rx_st_nxt;
            rdata         <= rdata_nxt;
        end
    end

    assign tx_last = brk_r ? lbw_pkg::BRK_BITS - 4'h1
                           : lbw_pkg::DATA_BITS - 4'h1;

    // transmitter: one holding byte in front of the shifter
    always_comb begin
        txh_nxt      = txh_r;
        txh_full_nxt = txh_full_r;
        tsr_nxt      = tsr_r;
        brk_nxt      = brk_r;
        tx_cnt_nxt   = tx_cnt_r;
        tx_bits_nxt  = tx_bits_r;
        tx_st_nxt    = tx_st_r;
        send_break_bit_clr    = 1'b0;
        case (tx_st_r)
            lbw_pkg::TX_IDLE: begin
                if (txh_full_r && ctrl_r.tx_enable_bit) begin
                    // R9 break frame sends zeros, not the byte
                    brk_nxt      = ctrl_r.send_break_bit;
                    tsr_nxt      = ctrl_r.send_break_bit ? lbw_pkg::BRK_DATA
                                                         : txh_r;
                    txh_full_nxt = 1'b0;
                    tx_st_nxt    = lbw_pkg::TX_START;
                    tx_cnt_nxt   = baud_r - 16'h0001;
                end
            end
            lbw_pkg::TX_START: begin
                // R21 every bit uses the baud divisor
                if (tx_cnt_r == 16'h0000) begin
                    tx_st_nxt   = lbw_pkg::TX_DATA;
                    tx_cnt_nxt  = baud_r - 16'h0001;
                    tx_bits_nxt = 4'h0;
                end else begin
                    tx_cnt_nxt = tx_cnt_r - 16'h0001;
                end
            end
            lbw_pkg::TX_DATA: begin
                // R8 twelve zero bits for a break
                if (tx_cnt_r == 16'h0000) begin
                    tx_cnt_nxt  = baud_r - 16'h0001;
                    tx_bits_nxt = tx_bits_r + 4'h1;
                    tsr_nxt     = {1'b0, tsr_r[7:1]};
                    if (tx_bits_r == tx_last) begin
                        tx_st_nxt = lbw_pkg::TX_STOP;
                    end
                end else begin
                    tx_cnt_nxt = tx_cnt_r - 16'h0001;
                end
            end
            lbw_pkg::TX_STOP: begin
                if (tx_cnt_r == 16'h0000) begin
                    // R10 clear send-break once stop bit is out
                    send_break_bit_clr = brk_r;
                    tx_st_nxt = lbw_pkg::TX_IDLE;
                end else begin
                    tx_cnt_nxt = tx_cnt_r - 16'h0001;
                end
            end
            default: tx_st_nxt = lbw_pkg::TX_IDLE;
        endcase
        // writes to a full holding register are dropped, unless it loads into the shifter in that cycle
        if (wr && addr == lbw_pkg::ADDR_TXD && ctrl_r.tx_enable_bit
            && !txh_full_nxt) begin
            txh_nxt      = wdata[7:0];
            txh_full_nxt = 1'b1;
        end
        case (tx_st_nxt)
            lbw_pkg::TX_START: tx_line_nxt = 1'b0;
            lbw_pkg::TX_DATA:  tx_line_nxt = brk_nxt ? 1'b0 : tsr_nxt[0];
            default:           tx_line_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            txh_r         <= 8'h00;
            txh_full_r    <= 1'b0;
            tsr_r         <= 8'h00;
            brk_r         <= 1'b0;
            tx_cnt_r      <= 16'h0000;
            tx_bits_r     <= 4'h0;
            tx_st_r       <= lbw_pkg::TX_IDLE;
            tx_line       <= 1'b1;
            tx_ready_flag <= 1'b1;
        end else begin
            txh_r         <= txh_nxt;
            txh_full_r    <= txh_full_nxt;
            tsr_r         <= tsr_nxt;
            brk_r         <= brk_nxt;
            tx_cnt_r      <= tx_cnt_nxt;
            tx_bits_r     <= tx_bits_nxt;
            tx_st_r       <= tx_st_nxt;
            tx_line       <= tx_line_nxt;
            // R13 ready mirrors an empty holding register
            tx_ready_flag <= ~txh_full_nxt;
        end
    end

    // checks
    sequence s_brk_data;
        tx_st_r == lbw_pkg::TX_DATA && brk_r;
    endsequence
    property p_wake_flag;
        @(posedge clk) disable iff (!rstn)
        ctrl_r.wake_arm && ctrl_r.async_mode && fall && !wake_seen_r
        |=> rx_ready_flag;
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("no wake flag"); // R3
    property p_wake_clr;
        @(posedge clk) disable iff (!rstn)
        ctrl_r.wake_arm && wake_seen_r && rise && !wr |=> !ctrl_r.wake_arm;
    endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("wake arm kept"); // R4
    property p_rd_clr;
        @(posedge clk) disable iff (!rstn)
        rd && addr == lbw_pkg::ADDR_RXD && !rx_set && !wake_ev
        |=> !rx_ready_flag;
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("ready not dropped"); // R5
    property p_rx_park;
        @(posedge clk) disable iff (!rstn)
        ctrl_r.wake_arm |=> rx_st_r == lbw_pkg::RX_IDLE;
    endproperty
    a_rx_park: assert property (p_rx_park) else $error("rx not idle"); // R7
    property p_brk_zero;
        @(posedge clk) disable iff (!rstn)
        s_brk_data |-> !tx_line;
    endproperty
    a_brk_zero: assert property (p_brk_zero) else $error("break bit high"); // R8
    property p_brk_len;
        @(posedge clk) disable iff (!rstn)
        s_brk_data ##1 (tx_st_r == lbw_pkg::TX_STOP)
        |-> $past(tx_bits_r) == lbw_pkg::BRK_BITS - 4'h1 && tx_line;
    endproperty
    a_brk_len: assert property (p_brk_len) else $error("break length"); // R8
    property p_send_break_bit;
        @(posedge clk) disable iff (!rstn)
        send_break_bit_clr && !wr |=> !ctrl_r.send_break_bit;
    endproperty
    a_send_break_bit: assert property (p_send_break_bit) else $error("send-break kept"); // R10
    // a txd write in the load cycle refills the holding register at once
    property p_txrdy_load;
        @(posedge clk) disable iff (!rstn)
        tx_st_r == lbw_pkg::TX_IDLE && txh_full_r && ctrl_r.tx_enable_bit
        && !(wr && addr == lbw_pkg::ADDR_TXD)
        |=> tx_ready_flag && tx_st_r == lbw_pkg::TX_START;
    endproperty
    a_txrdy_load: assert property (p_txrdy_load) else $error("tx ready"); // R13
    property p_rx_brk;
        @(posedge clk) disable iff (!rstn)
        rx_st_r == lbw_pkg::RX_STOP && rx_cnt_r == 16'h0000
        && !rx_data_line && rsh_r == 8'h00 && !ctrl_r.wake_arm
        && !ctrl_r.autobaud_arm
        |=> rx_ready_flag && framing_error_flag_r && rxd_r == lbw_pkg::BRK_DATA;
    endproperty
    a_rx_brk: assert property (p_rx_brk) else $error("break not seen"); // R14
endmodule : lbw_top

// ===== testbench/lbw_remote.sv
`timescale 1ns/1ps
module lbw_remote (
    input  wire logic        clk,
    input  wire logic [15:0] bit_n,
    input  wire logic        tx_line,
    output logic             rx_data_line
);
    logic [7:0] got_q[$];
    int         run_q[$];
    int         low_cnt;
    logic [7:0] sh;

    // idle high between frames, like a pulled-up line
    initial rx_data_line = 1'b1;

    // hold one level for a whole number of bit times
    task automatic drive(input logic lvl, input int bits);
        rx_data_line <= lvl;
        repeat (bits * bit_n) @(posedge clk);
    endtask : drive

    task automatic send_low(input int bits);
        @(posedge clk);
        drive(1'b0, bits);
        drive(1'b1, 2);
    endtask : send_low

    // plain 8N1 frame, lsb first
    task automatic send_byte(input logic [7:0] b);
        @(posedge clk);
        drive(1'b0, 1);
        for (int i = 0; i < 8; i++) begin
            drive(b[i], 1);
        end
        drive(1'b1, 2);
    endtask : send_byte

    // length of every low stretch on tx, in clock cycles
    always @(posedge clk) begin
        low_cnt <= tx_line ? 0 : low_cnt + 1;
        if (tx_line && low_cnt != 0) begin
            run_q.push_back(low_cnt);
        end
    end

    // mid-bit sampling; a break just keeps the line low longer
    initial begin
        forever begin
            @(negedge tx_line);
            repeat (bit_n + bit_n / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                sh[i] = tx_line;
                repeat (bit_n) @(posedge clk);
            end
            got_q.push_back(sh);
            while (!tx_line) @(posedge clk);
        end
    end
endmodule : lbw_remote

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam int N = 16;
    logic        clk;
    logic        rstn;
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        rx_data_line;
    logic        tx_line;
    logic        rx_ready_flag;
    logic        tx_ready_flag;
    logic [15:0] bit_n;
    logic [15:0] v;
    int          fails;
    int          checks_done;

    lbw_top i_lbw_top (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rx_data_line(rx_data_line),
        .tx_line(tx_line), .rx_ready_flag(rx_ready_flag),
        .tx_ready_flag(tx_ready_flag));
    lbw_remote i_lbw_remote (.clk(clk), .bit_n(bit_n), .tx_line(tx_line),
        .rx_data_line(rx_data_line));

    // free-running system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) begin
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
            fails++;
        end
    endtask : chk

    // one-cycle strobes, changed just after the edge
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic rc(input logic [2:0] a, input logic [15:0] e,
                      input string m);
        logic [15:0] d;
        rd_reg(a, d);
        chk(d, e, m);
    endtask : rc

    // bounded wait: 0 rx ready, 1 tx ready, k>1 k-1 frames seen
    task automatic wait_for(input int sel, input int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            @(posedge clk);
            #1;
            if (sel == 0 && rx_ready_flag === 1'b1) break;
            if (sel == 1 && tx_ready_flag === 1'b1) break;
            if (sel > 1 && i_lbw_remote.got_q.size() >= sel - 1) break;
        end
        if (k == lim) begin
            $display("BAD %0t wait %0d ran out", $time, sel);
            fails++;
            stop_test();
        end
    endtask : wait_for

    task automatic t_reset();
        chk({15'h0, tx_line}, 16'h0001, "tx idle");
        rc(lbw_pkg::ADDR_CTRL, 16'h0010, "ctrl reset");
        rc(lbw_pkg::ADDR_STAT, 16'h001c, "stat reset");
        rc(lbw_pkg::ADDR_BAUD, 16'h0364, "baud reset");
        wr_reg(3'h5, 16'hffff);
        rc(3'h5, 16'h0000, "unmapped");
        wr_reg(lbw_pkg::ADDR_BAUD, 16'(N));
        rc(lbw_pkg::ADDR_BAUD, 16'(N), "baud write");
    endtask : t_reset

    task automatic t_header();
        i_lbw_remote.got_q.delete();
        i_lbw_remote.run_q.delete();
        wr_reg(lbw_pkg::ADDR_CTRL, 16'h0013);
        wr_reg(lbw_pkg::ADDR_TXD, 16'h00ff);
        wait_for(1, 8);
        rd_reg(lbw_pkg::ADDR_STAT, v);
        chk(v & 16'h0008, 16'h0000, "busy in break");
        rc(lbw_pkg::ADDR_CTRL, 16'h0013, "break armed");
        wr_reg(lbw_pkg::ADDR_TXD, 16'h0055);
        wait_for(3, 30 * N);
        chk({8'h00, i_lbw_remote.got_q[0]}, 16'h0000, "break zeros");
        chk(16'(i_lbw_remote.run_q[0]), 16'(13 * N), "break len");
        chk({8'h00, i_lbw_remote.got_q[1]}, 16'h0055, "sync");
        rc(lbw_pkg::ADDR_CTRL, 16'h0011, "break cleared");
        wait_for(1, 4);
        // sync frame still has the second half of its stop bit to go
        repeat (2 * N) @(posedge clk);
        rd_reg(lbw_pkg::ADDR_STAT, v);
        chk(v & 16'h000c, 16'h000c, "tx idle after");
    endtask : t_header

    task automatic t_rx();
        i_lbw_remote.send_low(13);
        wait_for(0, 4 * N);
        rd_reg(lbw_pkg::ADDR_STAT, v);
        chk(v & 16'h0003, 16'h0003, "break flags");
        rc(lbw_pkg::ADDR_RXD, 16'h0000, "break data");
        chk({15'h0, rx_ready_flag}, 16'h0000, "read clears");
        i_lbw_remote.send_byte(8'h3c);
        wait_for(0, 4 * N);
        rd_reg(lbw_pkg::ADDR_STAT, v);
        chk(v & 16'h0003, 16'h0001, "plain byte flags");
        rc(lbw_pkg::ADDR_RXD, 16'h003c, "plain byte");
    endtask : t_rx

    task automatic t_wake();
        rd_reg(lbw_pkg::ADDR_STAT, v);
        chk(v & 16'h0010, 16'h0010, "idle before arm");
        wr_reg(lbw_pkg::ADDR_CTRL, 16'h0014);
        @(posedge clk);
        i_lbw_remote.drive(1'b0, 0);
        wait_for(0, 4);
        repeat (13 * N) @(posedge clk);
        rc(lbw_pkg::ADDR_CTRL, 16'h0014, "still armed");
        rd_reg(lbw_pkg::ADDR_STAT, v);
        chk(v & 16'h0012, 16'h0010, "rx held idle");
        @(posedge clk);
        i_lbw_remote.drive(1'b1, 0);
        repeat (3) @(posedge clk);
        rc(lbw_pkg::ADDR_CTRL, 16'h0010, "rise disarms");
        rd_reg(lbw_pkg::ADDR_RXD, v);
        chk({15'h0, rx_ready_flag}, 16'h0000, "wake cleared");
        i_lbw_remote.send_byte(8'h5a);
        wait_for(0, 2 * N);
        rc(lbw_pkg::ADDR_RXD, 16'h005a, "byte after wake");
        wr_reg(lbw_pkg::ADDR_CTRL, 16'h0014);
        i_lbw_remote.send_byte(8'hf0);
        chk({15'h0, rx_ready_flag}, 16'h0001, "nonzero wakes");
        rc(lbw_pkg::ADDR_CTRL, 16'h0010, "first rise");
        rd_reg(lbw_pkg::ADDR_RXD, v);
    endtask : t_wake

    task automatic t_sync_mode();
        wr_reg(lbw_pkg::ADDR_CTRL, 16'h0004);
        @(posedge clk);
        i_lbw_remote.drive(1'b0, 0);
        repeat (4) @(posedge clk);
        i_lbw_remote.drive(1'b1, 0);
        repeat (2 * N) @(posedge clk);
        chk({15'h0, rx_ready_flag}, 16'h0000, "no wake");
        wr_reg(lbw_pkg::ADDR_CTRL, 16'h0010);
    endtask : t_sync_mode

    task automatic t_autobaud();
        wr_reg(lbw_pkg::ADDR_CTRL, 16'h001c);
        i_lbw_remote.send_low(13);
        rd_reg(lbw_pkg::ADDR_RXD, v);
        bit_n = 16'h0018;
        i_lbw_remote.send_byte(8'h55);
        wait_for(0, 2 * N);
        rd_reg(lbw_pkg::ADDR_BAUD, v);
        chk({15'h0, v >= 16'h0016 && v <= 16'h001a}, 16'h0001, "baud");
        rc(lbw_pkg::ADDR_CTRL, 16'h0010, "arms cleared");
        rd_reg(lbw_pkg::ADDR_RXD, v);
        bit_n = 16'(N);
        wr_reg(lbw_pkg::ADDR_BAUD, 16'(N));
    endtask : t_autobaud

    // main sequence; reset held for twelve cycles
    initial begin
        rstn        = 1'b0;
        addr        = 3'h0;
        wdata       = 16'h0000;
        wr          = 1'b0;
        rd          = 1'b0;
        bit_n       = 16'(N);
        fails       = 0;
        checks_done = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_header();
        t_rx();
        t_wake();
        t_sync_mode();
        t_autobaud();
        // second reset in mid-run, cuts the stray receive after autobaud
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        stop_test();
    end
endmodule : testbench
